/* File: fsx_pkg.sv */
// constants, types and helpers for the single-precision float state unit
// assumes one clock and a synchronous reset shared with the host cpu
// Contract
// - sixteen 32-bit float registers, 4-bit designators
// - multiply-accumulate uses register zero implicitly
// - cpu exchanges values via transfer register
// - status/control readable and writable by user code
// - value results round toward zero only
// - denormal sources of non-copy instructions and results become zero
// - only invalid and divide-by-zero are detected
// - other status bits fixed, ignore writes
// - every instruction rewrites both cause bits
// - trap only when cause and enable set
// - flags sticky until status register write
// - invalid disabled gives quiet nan result
// - divide-by-zero disabled gives signed infinity
// - sign 31, exponent 30:23, bias 127
// - exponent all ones/zeros decode as specials
// - nan bit 22 set means signaling
// - signaling nan: quiet nan or trap, no write
// - quiet nan input gives quiet nan, no trap
// - all enabled exceptions share one event
// - overflow gives max finite, underflow signed zero
// - data registers need no reset value
package fsx_pkg;

	// ------------------------------------------------------------
	// number format
	// ------------------------------------------------------------
	localparam int FR_COUNT = 16;
	localparam int SIGN_POS = 31;
	localparam int EXP_HI = 30;
	localparam int EXP_LO = 23;
	localparam int QUIET_SEL_POS = 22;
	localparam int EXP_BIAS = 127;
	localparam int EXP_MIN = -126;
	localparam int EXP_MAX = 127;
	localparam logic [7:0] EXP_ONES = 8'hff;
	localparam logic signed [9:0] EXP_OVF = 10'sh0ff;
	localparam logic [31:0] QNAN_VAL = 32'h7fbf_ffff;
	localparam logic [31:0] INF_MAG = 32'h7f80_0000;
	localparam logic [31:0] MAX_FIN_MAG = 32'h7f7f_ffff;

	// ------------------------------------------------------------
	// status/control layout
	// ------------------------------------------------------------
	localparam int CAUSE_V_POS = 16;
	localparam int CAUSE_Z_POS = 15;
	localparam int EN_V_POS = 11;
	localparam int EN_Z_POS = 10;
	localparam int FLAG_V_POS = 6;
	localparam int FLAG_Z_POS = 5;
	localparam logic [31:0] STATUS_RSV_VAL = 32'h0000_0001;
	localparam logic [31:0] STATUS_RW_MASK = 32'h0001_8c60;
	localparam logic [1:0] FIELD_RESET = 2'h0;

	typedef enum logic {FSX_SYS_STATUS = 1'b0, FSX_SYS_XFER = 1'b1} fsx_sys_type;

	typedef enum logic [3:0] {
		FSX_OP_COPY = 4'h0, FSX_OP_TO_XFER = 4'h1, FSX_OP_FROM_XFER = 4'h2,
		FSX_OP_ADD = 4'h3, FSX_OP_SUB = 4'h4, FSX_OP_MUL = 4'h5, FSX_OP_DIV = 4'h6,
		FSX_OP_MAC = 4'h7, FSX_OP_CMP = 4'h8, FSX_OP_TRUNC = 4'h9, FSX_OP_FLT = 4'ha
	} fsx_op_type;

	typedef struct packed {
		fsx_op_type op;
		logic [3:0] dst;
		logic [3:0] src;
	} fsx_issue_type;

	typedef struct packed {
		fsx_op_type op;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		logic [31:0] ival;
	} fsx_core_req_type;

	typedef struct packed {
		logic inv;
		logic cmp;
		logic nan;
		logic inf;
		logic sign;
		logic signed [9:0] exp;
		logic [25:0] mant;
		logic [31:0] ival;
	} fsx_core_res_type;

	function automatic logic is_nan(input logic [31:0] x);
		return (x[EXP_HI:EXP_LO] == EXP_ONES) && (|x[QUIET_SEL_POS:0]);
	endfunction

	function automatic logic is_snan(input logic [31:0] x);
		return (x[EXP_HI:EXP_LO] == EXP_ONES) && x[QUIET_SEL_POS];
	endfunction

	function automatic logic is_inf(input logic [31:0] x);
		return (x[EXP_HI:EXP_LO] == EXP_ONES) && !(|x[QUIET_SEL_POS:0]);
	endfunction

	function automatic logic [31:0] flush_den(input logic [31:0] x);
		return (x[EXP_HI:EXP_LO] == 8'h00) ? {x[SIGN_POS], 31'h0} : x;
	endfunction

	function automatic logic [31:0] pack_rtz(input fsx_core_res_type r);
		logic [31:0] v;
		v = {r.sign, 31'h0};
		if (r.inf)
			v = {r.sign, INF_MAG[30:0]};
		else if (!r.mant[25] || r.exp <= 10'sh000)
			v = {r.sign, 31'h0};
		else if (r.exp >= EXP_OVF)
			v = {r.sign, MAX_FIN_MAG[30:0]};
		else
			v = {r.sign, r.exp[7:0], r.mant[24:2]};
		return v;
	endfunction

endpackage

/* File: fsx_unit.sv */
// float register file, transfer register, status/control and exceptions
// assumes an external arithmetic core and a cpu that waits on busy_out
`timescale 1ns/100ps
module fsx_unit
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic issue_valid_in,
	input wire fsx_pkg::fsx_issue_type issue_in,
	output logic busy_out,
	output fsx_pkg::fsx_core_req_type core_req_out,
	output logic core_start_out,
	input wire logic core_done_in,
	input wire fsx_pkg::fsx_core_res_type core_res_in,
	input wire logic sys_wr_in,
	input wire fsx_pkg::fsx_sys_type sys_sel_in,
	input wire logic [31:0] sys_wdata_in,
	output logic [31:0] sys_rdata_out,
	output logic t_bit_out,
	output logic exc_req_out
);

	typedef enum logic [1:0] {S_IDLE = 2'b00, S_BUSY = 2'b01, S_FIN = 2'b11} fsx_state_type;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [31:0] fr_mem [fsx_pkg::FR_COUNT];
	logic [31:0] xfer_q;
	fsx_state_type state_q, state_d;
	fsx_pkg::fsx_op_type op_q;
	logic [3:0] dst_q;
	logic inv_q, dz_q, qn_q, sign_q;
	fsx_pkg::fsx_core_res_type rc_q;
	logic [1:0] cause_q, cause_d, en_q, en_d, flag_q, flag_d;
	logic [31:0] rdata_q;
	logic t_q, exc_q, start_q, busy_q;
	fsx_pkg::fsx_core_req_type req_q;

	// ------------------------------------------------------------
	// issue decode
	// ------------------------------------------------------------
	wire fsx_pkg::fsx_op_type op = issue_in.op;
	wire take = issue_valid_in && (state_q == S_IDLE);
	wire [31:0] raw_a = fr_mem[issue_in.dst];
	wire [31:0] raw_b = fr_mem[issue_in.src];
	wire [31:0] raw_c = fr_mem[0];
	wire is_copy = (op == fsx_pkg::FSX_OP_COPY) || (op == fsx_pkg::FSX_OP_TO_XFER)
		|| (op == fsx_pkg::FSX_OP_FROM_XFER);
	wire use_c = (op == fsx_pkg::FSX_OP_MAC);
	wire use_a = use_c || (op == fsx_pkg::FSX_OP_ADD) || (op == fsx_pkg::FSX_OP_SUB)
		|| (op == fsx_pkg::FSX_OP_MUL) || (op == fsx_pkg::FSX_OP_DIV)
		|| (op == fsx_pkg::FSX_OP_CMP);
	wire use_b = use_a || (op == fsx_pkg::FSX_OP_TRUNC);
	wire val_op = use_a && (op != fsx_pkg::FSX_OP_CMP) || (op == fsx_pkg::FSX_OP_FLT);

	// denormal sources are flushed before non-copy use; copies take raw_b
	wire [31:0] fa = fsx_pkg::flush_den(raw_a);
	wire [31:0] fb = fsx_pkg::flush_den(raw_b);
	wire [31:0] fc = fsx_pkg::flush_den(raw_c);

	// classification of the operands in use
	wire any_snan = (use_a && fsx_pkg::is_snan(fa)) || (use_b && fsx_pkg::is_snan(fb))
		|| (use_c && fsx_pkg::is_snan(fc));
	wire any_nan = (use_a && fsx_pkg::is_nan(fa)) || (use_b && fsx_pkg::is_nan(fb))
		|| (use_c && fsx_pkg::is_nan(fc));
	wire a_zero = (fa[30:0] == 31'h0);
	wire b_zero = (fb[30:0] == 31'h0);
	wire is_div = (op == fsx_pkg::FSX_OP_DIV);
	wire pre_inv = any_snan || (is_div && a_zero && b_zero);
	wire pre_dz = is_div && b_zero && !a_zero && !any_nan && !fsx_pkg::is_inf(fa);
	wire pre_qn = any_nan && !any_snan;
	wire skip_core = val_op && (pre_inv || pre_dz || pre_qn);

	// ------------------------------------------------------------
	// completion of a non-copy instruction
	// ------------------------------------------------------------
	wire fin = (state_q == S_FIN);
	wire inv_all = inv_q || rc_q.inv;
	wire trap = (inv_all && en_q[1]) || (dz_q && en_q[0]);
	wire fin_val = (op_q != fsx_pkg::FSX_OP_CMP) && (op_q != fsx_pkg::FSX_OP_TRUNC);
	wire [31:0] fin_res = (inv_all || qn_q || rc_q.nan) ? fsx_pkg::QNAN_VAL
		: dz_q ? {sign_q, fsx_pkg::INF_MAG[30:0]}
		: fsx_pkg::pack_rtz(rc_q);
	wire copy_take = take && is_copy;

	// register file write port, one writer per cycle
	wire fr_wr_en = (fin && fin_val && !trap)
		|| (copy_take && op != fsx_pkg::FSX_OP_TO_XFER);
	wire [3:0] fr_wr_idx = fin ? dst_q : issue_in.dst;
	wire [31:0] fr_wr_val = fin ? fin_res
		: (op == fsx_pkg::FSX_OP_FROM_XFER) ? xfer_q : raw_b;

	// transfer register sources, hardware before software
	wire xf_fin = fin && (op_q == fsx_pkg::FSX_OP_TRUNC) && !trap;
	wire xf_copy = copy_take && (op == fsx_pkg::FSX_OP_TO_XFER);
	wire xf_sys = sys_wr_in && (sys_sel_in == fsx_pkg::FSX_SYS_XFER);
	wire st_sys = sys_wr_in && (sys_sel_in == fsx_pkg::FSX_SYS_STATUS);

	// status word: reserved bits are constants
	wire [31:0] status_word = fsx_pkg::STATUS_RSV_VAL
		| (32'(cause_q[1]) << fsx_pkg::CAUSE_V_POS)
		| (32'(cause_q[0]) << fsx_pkg::CAUSE_Z_POS)
		| (32'(en_q[1]) << fsx_pkg::EN_V_POS)
		| (32'(en_q[0]) << fsx_pkg::EN_Z_POS)
		| (32'(flag_q[1]) << fsx_pkg::FLAG_V_POS)
		| (32'(flag_q[0]) << fsx_pkg::FLAG_Z_POS);
	wire [1:0] wr_cause = {sys_wdata_in[fsx_pkg::CAUSE_V_POS], sys_wdata_in[fsx_pkg::CAUSE_Z_POS]};
	wire [1:0] wr_en = {sys_wdata_in[fsx_pkg::EN_V_POS], sys_wdata_in[fsx_pkg::EN_Z_POS]};
	wire [1:0] wr_flag = {sys_wdata_in[fsx_pkg::FLAG_V_POS], sys_wdata_in[fsx_pkg::FLAG_Z_POS]};
	wire [1:0] events = fin ? {inv_all, dz_q} : 2'h0;

	// field next values; instruction outcome wins over a software write
	assign cause_d = fin ? events : copy_take ? 2'h0
		: st_sys ? wr_cause : cause_q;
	assign en_d = st_sys ? wr_en : en_q;
	assign flag_d = (st_sys ? wr_flag : flag_q) | events;

	// sequencing of one outstanding instruction
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE:
			begin
				if (take && !is_copy)
					state_d = skip_core ? S_FIN : S_BUSY;
			end
			S_BUSY:
			begin
				if (core_done_in)
					state_d = S_FIN;
			end
			S_FIN:
				state_d = S_IDLE;
			default:
				state_d = S_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// data registers, left without reset
	// ------------------------------------------------------------
	// register file write
	always_ff @(posedge mclk_in)
	begin
		if (fr_wr_en)
			fr_mem[fr_wr_idx] <= fr_wr_val;
	end

	// transfer register
	always_ff @(posedge mclk_in)
	begin
		if (xf_fin)
			xfer_q <= rc_q.ival;
		else if (xf_copy)
			xfer_q <= raw_b;
		else if (xf_sys)
			xfer_q <= sys_wdata_in;
	end

	// latched instruction context
	always_ff @(posedge mclk_in)
	begin
		if (take)
		begin
			op_q <= op;
			dst_q <= issue_in.dst;
			sign_q <= fa[fsx_pkg::SIGN_POS] ^ fb[fsx_pkg::SIGN_POS];
			req_q <= '{op: op, a: fa, b: fb, c: fc, ival: xfer_q};
		end
	end

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	// state and pre-detected conditions
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			state_q <= S_IDLE;
			{inv_q, dz_q, qn_q} <= 3'h0;
			rc_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (take)
				{inv_q, dz_q, qn_q} <= {pre_inv, pre_dz && !pre_inv, pre_qn};
			if (take)
				rc_q <= '0;
			else if (state_q == S_BUSY && core_done_in)
				rc_q <= core_res_in;
		end
	end

	// status fields and outputs
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			cause_q <= fsx_pkg::FIELD_RESET;
			en_q <= fsx_pkg::FIELD_RESET;
			flag_q <= fsx_pkg::FIELD_RESET;
			{t_q, exc_q, start_q, busy_q} <= 4'h0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			cause_q <= cause_d;
			en_q <= en_d;
			flag_q <= flag_d;
			exc_q <= fin && trap;
			start_q <= take && !is_copy && !skip_core;
			busy_q <= (state_d != S_IDLE);
			rdata_q <= (sys_sel_in == fsx_pkg::FSX_SYS_STATUS) ? status_word : xfer_q;
			if (fin && op_q == fsx_pkg::FSX_OP_CMP)
				t_q <= rc_q.cmp && !inv_all && !qn_q;
		end
	end

	assign busy_out = busy_q;
	assign core_req_out = req_q;
	assign core_start_out = start_q;
	assign sys_rdata_out = rdata_q;
	assign t_bit_out = t_q;
	assign exc_req_out = exc_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	property p_exc_pulse;
		exc_req_out |=> !exc_req_out;
	endproperty
	a_exc_pulse: assert property (p_exc_pulse) else $error("exception held");

	property p_exc_cause;
		exc_req_out |-> (cause_q[1] && en_q[1]) || (cause_q[0] && en_q[0]);
	endproperty
	a_exc_cause: assert property (p_exc_cause) else $error("trap w/o cause");

	property p_flag_sticky;
		(flag_q != 2'h0 && !st_sys) |=> ((flag_q & $past(flag_q)) == $past(flag_q));
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

	property p_cause_flag;
		fin |=> (cause_q == $past(events)) && ((flag_q & cause_q) == cause_q);
	endproperty
	a_cause_flag: assert property (p_cause_flag) else $error("cause mismatch");

	// reserved bits are judged on the read port, where the cpu sees them;
	// the first read after reset still carries the cleared read register
	property p_reserved;
		(!$past(rst_in) && $past(sys_sel_in) == fsx_pkg::FSX_SYS_STATUS)
			|-> (sys_rdata_out & ~fsx_pkg::STATUS_RW_MASK) == fsx_pkg::STATUS_RSV_VAL;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits moved");

	// the core must never be handed a denormal operand
	property p_src_flush;
		core_start_out |-> (core_req_out.a[30:23] != 8'h00 || core_req_out.a[30:0] == 31'h0)
			&& (core_req_out.b[30:23] != 8'h00 || core_req_out.b[30:0] == 31'h0);
	endproperty
	a_src_flush: assert property (p_src_flush) else $error("denormal operand");

	// a quiet input alone never traps and leaves no cause behind
	property p_qn_no_trap;
		(fin && qn_q && !rc_q.inv) |=> !exc_req_out && cause_q == 2'h0;
	endproperty
	a_qn_no_trap: assert property (p_qn_no_trap) else $error("quiet nan trapped");

	// an oversized core result saturates to the largest finite value
	property p_ovf_max;
		(fin && fin_val && !trap && !inv_all && !qn_q && !dz_q && !rc_q.nan && !rc_q.inf
			&& rc_q.mant[25] && rc_q.exp >= fsx_pkg::EXP_OVF)
			|-> fr_wr_en && fr_wr_val == {rc_q.sign, fsx_pkg::MAX_FIN_MAG[30:0]};
	endproperty
	a_ovf_max: assert property (p_ovf_max) else $error("overflow not saturated");

	property p_trap_no_wb;
		(fin && trap) |-> !fr_wr_en ##1 exc_req_out;
	endproperty
	a_trap_no_wb: assert property (p_trap_no_wb) else $error("trap wrote back");

	property p_qnan_dis;
		(fin && fin_val && inv_all && !en_q[1]) |-> fr_wr_en && fr_wr_val == fsx_pkg::QNAN_VAL;
	endproperty
	a_qnan_dis: assert property (p_qnan_dis) else $error("no quiet nan");

	property p_dz_inf;
		(fin && dz_q && !inv_all && !en_q[0]) |-> fr_wr_val == {sign_q, fsx_pkg::INF_MAG[30:0]};
	endproperty
	a_dz_inf: assert property (p_dz_inf) else $error("no signed infinity");

	property p_copy_clear;
		copy_take |=> cause_q == 2'h0 && !exc_req_out;
	endproperty
	a_copy_clear: assert property (p_copy_clear) else $error("copy kept cause");

endmodule

/* File: fsx_core_model.sv */
// scripted arithmetic core that answers the float state unit
// assumes the bench sets the answer and its latency before each start
`timescale 1ns/100ps
module fsx_core_model
(
	input wire logic mclk_in,
	input wire logic start_in,
	input wire logic [3:0] lat_in,
	input wire fsx_pkg::fsx_core_res_type rsp_in,
	output logic done_out,
	output fsx_pkg::fsx_core_res_type res_out
);
	// ------------------------------------------------------------
	// answer timing
	// ------------------------------------------------------------
	logic [4:0] cnt_q = 5'h0;

	// one strobe per start, lat_in + 1 cycles after it
	always_ff @(posedge mclk_in)
	begin
		if (start_in)
			cnt_q <= {1'b0, lat_in} + 5'h1;
		else if (cnt_q != 5'h0)
			cnt_q <= cnt_q - 5'h1;
	end

	// result valid with the strobe only, inverted between answers
	assign done_out = (cnt_q == 5'h1);
	assign res_out = done_out ? rsp_in : ~rsp_in;
endmodule

/* File: tb.sv */
// self-checking bench for the float state unit
// assumes the scripted core model stands behind the core port
`timescale 1ns/100ps
module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic issue_valid_in = 1'b0;
	fsx_pkg::fsx_issue_type issue_in = '0;
	logic sys_wr_in = 1'b0;
	fsx_pkg::fsx_sys_type sys_sel_in = fsx_pkg::FSX_SYS_STATUS;
	logic [31:0] sys_wdata_in = 32'h0;
	logic [3:0] lat = 4'h0;
	fsx_pkg::fsx_core_res_type rsp = '0;
	logic busy_out, core_start_out, core_done_in, t_bit_out, exc_req_out;
	fsx_pkg::fsx_core_req_type core_req_out;
	fsx_pkg::fsx_core_res_type core_res_in;
	logic [31:0] sys_rdata_out;
	int err_total = 0;
	int n_checks = 0;
	int exc_cnt = 0;
	int cyc = 0;

	fsx_unit i_fsx_unit (.mclk_in(mclk_in), .rst_in(rst_in), .issue_valid_in(issue_valid_in),
		.issue_in(issue_in), .busy_out(busy_out), .core_req_out(core_req_out),
		.core_start_out(core_start_out), .core_done_in(core_done_in),
		.core_res_in(core_res_in), .sys_wr_in(sys_wr_in), .sys_sel_in(sys_sel_in),
		.sys_wdata_in(sys_wdata_in), .sys_rdata_out(sys_rdata_out),
		.t_bit_out(t_bit_out), .exc_req_out(exc_req_out));
	fsx_core_model i_fsx_core_model (.mclk_in(mclk_in), .start_in(core_start_out),
		.lat_in(lat), .rsp_in(rsp), .done_out(core_done_in), .res_out(core_res_in));

	// clock
	initial
	begin
		forever #5 mclk_in = ~mclk_in;
	end

	// count exception pulses away from the launching edge and cut a hang short
	always @(negedge mclk_in)
	begin
		cyc = cyc + 1;
		if (exc_req_out === 1'b1)
			exc_cnt = exc_cnt + 1;
		if (cyc == 20000)
		begin
			err_total = err_total + 1;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic sys_wr(input fsx_pkg::fsx_sys_type sel, input logic [31:0] d);
		@(negedge mclk_in);
		sys_wr_in = 1'b1;
		sys_sel_in = sel;
		sys_wdata_in = d;
		@(negedge mclk_in);
		sys_wr_in = 1'b0;
	endtask

	task automatic sys_rd(input fsx_pkg::fsx_sys_type sel, output logic [31:0] d);
		@(negedge mclk_in);
		sys_sel_in = sel;
		repeat (3) @(negedge mclk_in);
		d = sys_rdata_out;
	endtask

	// offer one instruction, then wait for idle and the exception window
	task automatic issue(input fsx_pkg::fsx_op_type op, input logic [3:0] dst,
		input logic [3:0] src);
		int n;
		@(negedge mclk_in);
		issue_valid_in = 1'b1;
		issue_in.op = op;
		issue_in.dst = dst;
		issue_in.src = src;
		@(negedge mclk_in);
		issue_valid_in = 1'b0;
		n = 0;
		@(negedge mclk_in);
		while (busy_out !== 1'b0 && n < 100)
		begin
			@(negedge mclk_in);
			n = n + 1;
		end
		if (busy_out !== 1'b0)
			err_total = err_total + 1;
		repeat (3) @(negedge mclk_in);
	endtask

	task automatic put(input logic [3:0] r, input logic [31:0] v);
		sys_wr(fsx_pkg::FSX_SYS_XFER, v);
		issue(fsx_pkg::FSX_OP_FROM_XFER, r, r);
	endtask

	task automatic chk_fr(input string nm, input logic [3:0] r, input logic [31:0] exp);
		logic [31:0] v;
		issue(fsx_pkg::FSX_OP_TO_XFER, r, r);
		sys_rd(fsx_pkg::FSX_SYS_XFER, v);
		chk(nm, v, exp);
	endtask

	task automatic chk_st(input string nm, input logic [31:0] exp);
		logic [31:0] v;
		sys_rd(fsx_pkg::FSX_SYS_STATUS, v);
		chk(nm, v, exp);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		chk_st("st_reset", 32'h0000_0001);
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'hffff_ffff);
		chk_st("st_ones", 32'h0001_8c61);
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'h0);
		chk_st("st_clear", 32'h0000_0001);
		for (int i = 0; i < 16; i++)
			put(i[3:0], 32'h0011_0000 + 32'(i));
		for (int i = 0; i < 16; i++)
			chk_fr("fr_copy", i[3:0], 32'h0011_0000 + 32'(i));
	endtask

	task automatic t_nan();
		int e0;
		logic [31:0] v;
		// invalid disabled: signaling input becomes quiet without a trap
		put(2, 32'h7fc0_0000);
		e0 = exc_cnt;
		issue(fsx_pkg::FSX_OP_ADD, 4'h2, 4'h2);
		chk("exc_off", 32'(exc_cnt - e0), 32'h0);
		chk_st("st_snan", 32'h0001_0041);
		issue(fsx_pkg::FSX_OP_TO_XFER, 4'h2, 4'h2);
		sys_rd(fsx_pkg::FSX_SYS_XFER, v);
		chk("qnan", 32'({v[30:22], |v[21:0]}), 32'h3fd);
		// invalid enabled: one trap, destination kept
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'h0000_0800);
		put(3, 32'hffc0_0001);
		e0 = exc_cnt;
		issue(fsx_pkg::FSX_OP_ADD, 4'h3, 4'h3);
		chk("exc_on", 32'(exc_cnt - e0), 32'h1);
		chk_st("st_trap", 32'h0001_0841);
		chk_fr("fr_kept", 3, 32'hffc0_0001);
		// quiet input with trap enabled: no trap, cause cleared, flag kept
		put(4, 32'h7f80_0001);
		e0 = exc_cnt;
		issue(fsx_pkg::FSX_OP_ADD, 4'h4, 4'h4);
		chk("exc_q", 32'(exc_cnt - e0), 32'h0);
		chk_st("st_q", 32'h0000_0841);
	endtask

	task automatic t_div();
		int e0;
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'h0);
		put(12, 32'h3f80_0000);
		put(13, 32'h8000_0000);
		rsp = '0;
		rsp.inf = 1'b1;
		rsp.sign = 1'b1;
		e0 = exc_cnt;
		issue(fsx_pkg::FSX_OP_DIV, 4'hc, 4'hd);
		chk("exc_dz_off", 32'(exc_cnt - e0), 32'h0);
		chk_st("st_dz", 32'h0000_8021);
		chk_fr("fr_inf", 12, 32'hff80_0000);
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'h0000_0400);
		put(14, 32'h3f80_0000);
		e0 = exc_cnt;
		issue(fsx_pkg::FSX_OP_DIV, 4'he, 4'hd);
		chk("exc_dz_on", 32'(exc_cnt - e0), 32'h1);
		chk_st("st_dz_on", 32'h0000_8421);
		chk_fr("fr_dz_kept", 14, 32'h3f80_0000);
	endtask

	task automatic t_core();
		logic [31:0] res_v [3] = '{32'h4000_0000, 32'h7f7f_ffff, 32'h8000_0000};
		logic signed [9:0] res_e [3] = '{10'sd128, 10'sd300, -10'sd5};
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'h0);
		put(0, 32'h4040_0000);
		put(6, 32'h0000_0001);
		put(7, 32'h3f80_0000);
		rsp = '0;
		issue(fsx_pkg::FSX_OP_MUL, 4'h7, 4'h6);
		chk("req_flush", core_req_out.b, 32'h0);
		chk_fr("fr_zero", 7, 32'h0);
		// a plain copy keeps a denormal as it is
		issue(fsx_pkg::FSX_OP_COPY, 4'hb, 4'h6);
		chk_fr("fr_raw", 11, 32'h0000_0001);
		put(7, 32'h3f80_0000);
		issue(fsx_pkg::FSX_OP_MAC, 4'h7, 4'h7);
		chk("req_index", core_req_out.c, 32'h4040_0000);
		// truncation, overflow and underflow, prompt and slow answers
		for (int i = 0; i < 3; i++)
		begin
			put(5, 32'h3f80_0000);
			rsp = '0;
			rsp.sign = (i == 2);
			rsp.exp = res_e[i];
			rsp.mant = 26'h200_0003;
			lat = 4'(i * 6);
			issue((i == 1) ? fsx_pkg::FSX_OP_SUB : fsx_pkg::FSX_OP_ADD, 4'h5, 4'h5);
			chk_st("st_core", 32'h0000_0001);
			chk_fr("fr_core", 5, res_v[i]);
		end
	endtask

	// compare result, quiet compare, truncation and conversion through the transfer register
	task automatic t_cmp();
		int e0;
		logic [31:0] v;
		sys_wr(fsx_pkg::FSX_SYS_STATUS, 32'h0000_0800);
		put(8, 32'h3f80_0000);
		put(9, 32'h7f80_0001);
		rsp = '0;
		rsp.cmp = 1'b1;
		lat = 4'h2;
		issue(fsx_pkg::FSX_OP_CMP, 4'h8, 4'h8);
		chk("t_set", 32'(t_bit_out), 32'h1);
		chk_st("st_cmp", 32'h0000_0801);
		e0 = exc_cnt;
		issue(fsx_pkg::FSX_OP_CMP, 4'h9, 4'h8);
		chk("t_qnan", 32'(t_bit_out), 32'h0);
		chk("exc_cmp", 32'(exc_cnt - e0), 32'h0);
		rsp.ival = 32'h0000_0007;
		issue(fsx_pkg::FSX_OP_TRUNC, 4'h8, 4'h8);
		sys_rd(fsx_pkg::FSX_SYS_XFER, v);
		chk("trunc", v, 32'h0000_0007);
		sys_wr(fsx_pkg::FSX_SYS_XFER, 32'h0000_0002);
		rsp.exp = 10'sd128;
		rsp.mant = 26'h200_0000;
		issue(fsx_pkg::FSX_OP_FLT, 4'hf, 4'hf);
		chk("req_ival", core_req_out.ival, 32'h0000_0002);
		chk_fr("fr_flt", 15, 32'h4000_0000);
	endtask

	// main sequence
	initial
	begin
		repeat (3) @(negedge mclk_in);
		rst_in = 1'b0;
		t_regs();
		t_nan();
		t_div();
		t_core();
		t_cmp();
		end_sim();
	end
endmodule
